// ---- pcu_pkg.sv ----
package pcu_pkg;

    // group geometry
    localparam int PCU_NGRP = 3;
    localparam int PCU_GW = 8;
    localparam int PCU_GW0 = 8;
    localparam int PCU_GW1 = 7;
    localparam int PCU_GW2 = 8;

    // register bus widths
    localparam int PCU_AW = 3;
    localparam int PCU_DW = 8;

    // register offsets
    localparam logic [PCU_AW-1:0] PCU_OFS_CTRL = 3'h0;
    localparam logic [PCU_AW-1:0] PCU_OFS_FLAGS = 3'h1;
    localparam logic [PCU_AW-1:0] PCU_OFS_MASK0 = 3'h2;
    localparam logic [PCU_AW-1:0] PCU_OFS_MASK1 = 3'h3;
    localparam logic [PCU_AW-1:0] PCU_OFS_MASK2 = 3'h4;

    // group indices, also the vector numbers
    localparam logic [1:0] PCU_GRP0 = 2'h0;
    localparam logic [1:0] PCU_GRP1 = 2'h1;
    localparam logic [1:0] PCU_GRP2 = 2'h2;

    // reset values
    localparam logic [PCU_NGRP-1:0] PCU_RST_CTRL = 3'h0;
    localparam logic [PCU_NGRP-1:0] PCU_RST_FLAGS = 3'h0;
    localparam logic [PCU_GW-1:0] PCU_RST_MASK = 8'h00;
    localparam logic [PCU_DW-1:0] PCU_RD_ZERO = 8'h00;

    typedef logic [PCU_NGRP-1:0][PCU_GW-1:0] pcu_pins_t;

    // register bus request
    typedef struct packed {
        logic [PCU_AW-1:0] addr;
        logic [PCU_DW-1:0] wdata;
        logic wr;
        logic rd;
    } pcu_bus_req_t;

    // whole state of the unit
    typedef struct packed {
        pcu_pins_t pin_now;
        pcu_pins_t pin_prev;
        logic [1:0] warm;
        logic [PCU_NGRP-1:0] enable;
        logic [PCU_NGRP-1:0] flags;
        pcu_pins_t mask;
        logic [PCU_DW-1:0] rdata;
    } pcu_state_t;

endpackage : pcu_pkg

// ---- pcu_pin_change.sv ----
// The strobed register port and the register offsets are this design's own decisions.
module pcu_pin_change #(
    parameter int GRP_W0 = pcu_pkg::PCU_GW0,
    parameter int GRP_W1 = pcu_pkg::PCU_GW1,
    parameter int GRP_W2 = pcu_pkg::PCU_GW2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire pcu_pkg::pcu_bus_req_t bus_req,
    output logic [pcu_pkg::PCU_DW-1:0] bus_rdata,
    // watched pins, unused group bits ignored
    input wire pcu_pkg::pcu_pins_t pins,
    // processor side
    input wire logic global_int_en,
    input wire logic irq_ack,
    output logic irq,
    output logic [1:0] irq_vector
);
    import pcu_pkg::*;

    localparam int GRP_W [PCU_NGRP] = '{GRP_W0, GRP_W1, GRP_W2};

    pcu_state_t s_q;
    pcu_state_t s_d;
    pcu_pins_t valid;
    logic [PCU_NGRP-1:0] hit;
    logic [PCU_NGRP-1:0] pending;

    // per group: implemented pins and change events
    for (genvar g = 0; g < PCU_NGRP; g++) begin : g_grp
        if (GRP_W[g] < 1 || GRP_W[g] > PCU_GW) begin : g_bad
            $error("group width out of range");
        end
        for (genvar b = 0; b < PCU_GW; b++) begin : g_bit
            assign valid[g][b] = (b < GRP_W[g]);
        end
        // both edges count; mask and group enable gate the event
        assign hit[g] = s_q.warm[1] && s_q.enable[g] &&
                        (|((s_q.pin_now[g] ^ s_q.pin_prev[g]) & s_q.mask[g]));
    end

    // a flag requests service only with group and global enable
    assign pending = s_q.flags & s_q.enable & {PCU_NGRP{global_int_en}};
    assign irq = |pending;

    // lowest group wins when several are pending
    always_comb begin
        if (pending[0]) begin
            irq_vector = PCU_GRP0;
        end else if (pending[1]) begin
            irq_vector = PCU_GRP1;
        end else begin
            irq_vector = PCU_GRP2;
        end
    end

    assign bus_rdata = s_q.rdata;

    // next state
    always_comb begin
        logic [PCU_NGRP-1:0] clr;
        clr = '0;
        s_d = s_q;
        s_d.pin_now = pins & valid;
        s_d.pin_prev = s_q.pin_now;
        // first sample after reset is not compared: prev is not real yet
        s_d.warm = {s_q.warm[0], 1'b1};
        if (bus_req.wr) begin
            case (bus_req.addr)
                PCU_OFS_CTRL: s_d.enable = bus_req.wdata[PCU_NGRP-1:0];
                PCU_OFS_FLAGS: clr = bus_req.wdata[PCU_NGRP-1:0];
                PCU_OFS_MASK0: s_d.mask[0] = bus_req.wdata & valid[0];
                PCU_OFS_MASK1: s_d.mask[1] = bus_req.wdata & valid[1];
                PCU_OFS_MASK2: s_d.mask[2] = bus_req.wdata & valid[2];
                default: ;
            endcase
        end
        // interrupt entry clears the group being served
        if (irq_ack && irq) begin
            clr[irq_vector] = 1'b1;
        end
        s_d.flags = (s_q.flags & ~clr) | hit;
        // read data stand for one cycle only
        s_d.rdata = PCU_RD_ZERO;
        if (bus_req.rd) begin
            case (bus_req.addr)
                PCU_OFS_CTRL: s_d.rdata = {{(PCU_DW-PCU_NGRP){1'b0}}, s_q.enable};
                PCU_OFS_FLAGS: s_d.rdata = {{(PCU_DW-PCU_NGRP){1'b0}}, s_q.flags};
                PCU_OFS_MASK0: s_d.rdata = s_q.mask[0];
                PCU_OFS_MASK1: s_d.rdata = s_q.mask[1];
                PCU_OFS_MASK2: s_d.rdata = s_q.mask[2];
                default: s_d.rdata = PCU_RD_ZERO;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{pin_now: '0, pin_prev: '0, warm: 2'h0, enable: PCU_RST_CTRL, flags: PCU_RST_FLAGS,
                     mask: {PCU_NGRP{PCU_RST_MASK}}, rdata: PCU_RD_ZERO};
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    chk_flag0_set: assert property (hit[0] |=> s_q.flags[0])
        else $error("group 0 event did not set flag");
    chk_flag1_set: assert property (hit[1] |=> s_q.flags[1])
        else $error("group 1 event did not set flag");
    chk_flag2_set: assert property (hit[2] |=> s_q.flags[2])
        else $error("group 2 event did not set flag");
    chk_w1c_clear: assert property (bus_req.wr && bus_req.addr == PCU_OFS_FLAGS && bus_req.wdata[1] && !hit[1]
                                    |=> !s_q.flags[1])
        else $error("write one did not clear flag");
    chk_ack_clear: assert property (irq_ack && irq && irq_vector == PCU_GRP2 && !hit[2] |=> !s_q.flags[2])
        else $error("interrupt entry did not clear flag");
    chk_vec_group0: assert property (s_q.flags[0] && s_q.enable[0] && global_int_en
                                     |-> irq && irq_vector == PCU_GRP0)
        else $error("group 0 request not on its vector");
    chk_no_gie: assert property (!global_int_en |-> !irq)
        else $error("interrupt without global enable");
    chk_flags_resv: assert property (bus_req.rd && bus_req.addr == PCU_OFS_FLAGS |=> bus_rdata[7:3] == 5'h00)
        else $error("reserved flag bits not zero");
    chk_mask1_top: assert property (bus_req.rd && bus_req.addr == PCU_OFS_MASK1 |=> !bus_rdata[7])
        else $error("group 1 mask top bit not zero");
    chk_masked_off: assert property (s_q.mask[1] == PCU_RST_MASK || !s_q.enable[1] |-> !hit[1])
        else $error("masked or disabled group produced event");
    chk_set_wins: assert property (hit[0] && bus_req.wr && bus_req.addr == PCU_OFS_FLAGS && bus_req.wdata[0]
                                   |=> s_q.flags[0])
        else $error("clear beat simultaneous set");
    chk_change_seen: assert property ($changed(s_q.pin_now[0][0]) && s_q.mask[0][0] && s_q.enable[0] && s_q.warm[1]
                                      |=> s_q.flags[0])
        else $error("pin change missed");

    // helper decodes shared by the checks below
    logic wr_flags;
    logic wr_ctrl;
    logic wr_mask;
    logic ack_taken;

    // one-cycle write strobes, split by target register
    assign wr_flags = bus_req.wr && (bus_req.addr == PCU_OFS_FLAGS);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == PCU_OFS_CTRL);
    assign wr_mask = bus_req.wr && (bus_req.addr >= PCU_OFS_MASK0) && (bus_req.addr <= PCU_OFS_MASK2);
    // an entry only counts while a request is up
    assign ack_taken = irq_ack && irq;

    // interrupt output: gated by group and global enable
    chk_irq_gie: assert property (irq |-> global_int_en)
        else $error("interrupt raised with global enable off");

    // a request always has a set and enabled flag behind it
    chk_irq_source: assert property (irq |-> |(s_q.flags & s_q.enable))
        else $error("interrupt without an enabled flag");

    // only the three group numbers are legal vectors
    chk_vec_range: assert property (irq |-> irq_vector <= PCU_GRP2)
        else $error("vector out of range");

    // the vector names a group that really asks
    chk_vec_pending: assert property (irq |-> s_q.flags[irq_vector] && s_q.enable[irq_vector])
        else $error("vector names a quiet group");

    // each group alone raises the output
    chk_grp0_irq: assert property (s_q.flags[0] && s_q.enable[0] && global_int_en |-> irq)
        else $error("group 0 request missing");

    chk_grp1_irq: assert property (s_q.flags[1] && s_q.enable[1] && global_int_en |-> irq)
        else $error("group 1 request missing");

    chk_grp2_irq: assert property (s_q.flags[2] && s_q.enable[2] && global_int_en |-> irq)
        else $error("group 2 request missing");

    // group 1 gets the vector when group 0 is quiet
    chk_vec_group1: assert property (s_q.flags[1] && s_q.enable[1] && global_int_en
                                     && !(s_q.flags[0] && s_q.enable[0]) |-> irq_vector == PCU_GRP1)
        else $error("group 1 request not on its vector");

    // group 2 only when both lower groups are quiet
    chk_vec_group2: assert property (s_q.flags[2] && s_q.enable[2] && global_int_en
                                     && !(s_q.flags[0] && s_q.enable[0]) && !(s_q.flags[1] && s_q.enable[1])
                                     |-> irq_vector == PCU_GRP2)
        else $error("group 2 request not on its vector");

    // all groups disabled: no request whatever the flags
    chk_irq_disabled: assert property (s_q.enable == PCU_RST_CTRL |-> !irq)
        else $error("interrupt with all groups disabled");

    // no flag, no request
    chk_irq_noflag: assert property (s_q.flags == PCU_RST_FLAGS |-> !irq)
        else $error("interrupt with no flag set");

    // change detection: rising and falling edges alike
    // history is not trusted until two samples are in
    chk_warm_quiet: assert property (!s_q.warm[1] |-> hit == '0)
        else $error("event before history primed");

    // a steady pin set never gives an event
    chk_still_quiet: assert property (s_q.pin_now == s_q.pin_prev |-> hit == '0)
        else $error("event without pin change");

    // the history register is the previous sample, nothing else
    chk_prev_follows: assert property (s_q.pin_prev == $past(s_q.pin_now))
        else $error("pin history out of step");

    // events need the group enable and some mask bit
    chk_hit0_cause: assert property (hit[0] |-> s_q.enable[0] && s_q.mask[0] != '0)
        else $error("group 0 event while disabled or masked");

    chk_hit1_cause: assert property (hit[1] |-> s_q.enable[1] && s_q.mask[1] != '0)
        else $error("group 1 event while disabled or masked");

    chk_hit2_cause: assert property (hit[2] |-> s_q.enable[2] && s_q.mask[2] != '0)
        else $error("group 2 event while disabled or masked");

    // an event implies the group's pins moved
    chk_hit0_edge: assert property (hit[0] |-> s_q.pin_now[0] != s_q.pin_prev[0])
        else $error("group 0 event on steady pins");

    chk_hit1_edge: assert property (hit[1] |-> s_q.pin_now[1] != s_q.pin_prev[1])
        else $error("group 1 event on steady pins");

    chk_hit2_edge: assert property (hit[2] |-> s_q.pin_now[2] != s_q.pin_prev[2])
        else $error("group 2 event on steady pins");

    // a rising pin in group 2 is caught
    chk_rise_seen: assert property ($rose(s_q.pin_now[2][0]) && s_q.mask[2][0]
                                    && s_q.enable[2] && s_q.warm[1] |=> s_q.flags[2])
        else $error("group 2 rising change missed");

    // a falling pin in group 1 is caught
    chk_fall_seen: assert property ($fell(s_q.pin_now[1][0]) && s_q.mask[1][0]
                                    && s_q.enable[1] && s_q.warm[1] |=> s_q.flags[1])
        else $error("group 1 falling change missed");

    // unimplemented pin of group 1 never enters the history
    chk_unused_pin: assert property ((s_q.pin_now[1] & ~valid[1]) == '0)
        else $error("unimplemented pin sampled");

    // flags: sticky, set only by events
    // no event, no new flag
    chk_flag0_idle: assert property (!hit[0] && !s_q.flags[0] |=> !s_q.flags[0])
        else $error("group 0 flag set without event");

    chk_flag1_idle: assert property (!hit[1] && !s_q.flags[1] |=> !s_q.flags[1])
        else $error("group 1 flag set without event");

    chk_flag2_idle: assert property (!hit[2] && !s_q.flags[2] |=> !s_q.flags[2])
        else $error("group 2 flag set without event");

    // a set flag stays until a clear reaches it
    chk_flag0_keep: assert property (s_q.flags[0] && !(wr_flags && bus_req.wdata[0])
                                     && !(ack_taken && irq_vector == PCU_GRP0) |=> s_q.flags[0])
        else $error("group 0 flag lost");

    chk_flag1_keep: assert property (s_q.flags[1] && !(wr_flags && bus_req.wdata[1])
                                     && !(ack_taken && irq_vector == PCU_GRP1) |=> s_q.flags[1])
        else $error("group 1 flag lost");

    chk_flag2_keep: assert property (s_q.flags[2] && !(wr_flags && bus_req.wdata[2])
                                     && !(ack_taken && irq_vector == PCU_GRP2) |=> s_q.flags[2])
        else $error("group 2 flag lost");

    // interrupt entry clears the served group
    chk_ack_clear0: assert property (ack_taken && irq_vector == PCU_GRP0 && !hit[0] |=> !s_q.flags[0])
        else $error("entry did not clear group 0 flag");

    chk_ack_clear1: assert property (ack_taken && irq_vector == PCU_GRP1 && !hit[1] |=> !s_q.flags[1])
        else $error("entry did not clear group 1 flag");

    // other groups are untouched by an entry
    chk_ack_served: assert property (ack_taken && irq_vector == PCU_GRP0 && s_q.flags[2]
                                     && !(wr_flags && bus_req.wdata[2]) |=> s_q.flags[2])
        else $error("entry cleared an unserved group");

    // write-one clears the addressed flag
    chk_w1c_clear0: assert property (wr_flags && bus_req.wdata[0] && !hit[0] |=> !s_q.flags[0])
        else $error("write one did not clear group 0 flag");

    chk_w1c_clear2: assert property (wr_flags && bus_req.wdata[2] && !hit[2] |=> !s_q.flags[2])
        else $error("write one did not clear group 2 flag");

    // a zero written leaves the flag alone
    chk_w0_keep: assert property (wr_flags && !bus_req.wdata[1] && s_q.flags[1]
                                  && !(ack_taken && irq_vector == PCU_GRP1) |=> s_q.flags[1])
        else $error("write zero cleared a flag");

    // a new event beats an entry clear
    chk_set_ack0: assert property (hit[0] && ack_taken |=> s_q.flags[0])
        else $error("entry clear beat group 0 event");

    chk_set_ack2: assert property (hit[2] && ack_taken |=> s_q.flags[2])
        else $error("entry clear beat group 2 event");

    // a new event beats a write-one clear
    chk_set_w1c1: assert property (hit[1] && wr_flags && bus_req.wdata[1] |=> s_q.flags[1])
        else $error("write clear beat group 1 event");

    chk_set_w1c2: assert property (hit[2] && wr_flags && bus_req.wdata[2] |=> s_q.flags[2])
        else $error("write clear beat group 2 event");

    // register port: data only in the cycle after the read strobe
    chk_rd_idle: assert property (!bus_req.rd |=> bus_rdata == PCU_RD_ZERO)
        else $error("read data outside its cycle");

    // control reads its bits and zeros above them
    chk_ctrl_rd: assert property (bus_req.rd && bus_req.addr == PCU_OFS_CTRL
                                  |=> bus_rdata[PCU_NGRP-1:0] == $past(s_q.enable))
        else $error("control read wrong");

    chk_ctrl_resv: assert property (bus_req.rd && bus_req.addr == PCU_OFS_CTRL
                                    |=> bus_rdata[PCU_DW-1:PCU_NGRP] == '0)
        else $error("control upper bits not zero");

    // flag reads return the flags of the strobe cycle
    chk_flags_rd: assert property (bus_req.rd && bus_req.addr == PCU_OFS_FLAGS
                                   |=> bus_rdata[PCU_NGRP-1:0] == $past(s_q.flags))
        else $error("flag read wrong");

    // masks read back what they hold
    chk_mask0_rd: assert property (bus_req.rd && bus_req.addr == PCU_OFS_MASK0
                                   |=> bus_rdata == $past(s_q.mask[0]))
        else $error("group 0 mask read wrong");

    chk_mask1_rd: assert property (bus_req.rd && bus_req.addr == PCU_OFS_MASK1
                                   |=> bus_rdata == $past(s_q.mask[1]))
        else $error("group 1 mask read wrong");

    chk_mask2_rd: assert property (bus_req.rd && bus_req.addr == PCU_OFS_MASK2
                                   |=> bus_rdata == $past(s_q.mask[2]))
        else $error("group 2 mask read wrong");

    // unmapped places read zero
    chk_unmapped_rd: assert property (bus_req.rd && bus_req.addr > PCU_OFS_MASK2 |=> bus_rdata == PCU_RD_ZERO)
        else $error("unmapped read not zero");

    // control takes the written enable bits
    chk_ctrl_wr: assert property (wr_ctrl |=> s_q.enable == $past(bus_req.wdata[PCU_NGRP-1:0]))
        else $error("control write lost");

    // control holds without a write to it
    chk_ctrl_hold: assert property (!wr_ctrl |=> $stable(s_q.enable))
        else $error("control changed without write");

    // masks take the written bits, unimplemented ones dropped
    chk_mask0_wr: assert property (bus_req.wr && bus_req.addr == PCU_OFS_MASK0
                                   |=> s_q.mask[0] == ($past(bus_req.wdata) & valid[0]))
        else $error("group 0 mask write lost");

    chk_mask1_wr: assert property (bus_req.wr && bus_req.addr == PCU_OFS_MASK1
                                   |=> s_q.mask[1] == ($past(bus_req.wdata) & valid[1]))
        else $error("group 1 mask write lost");

    chk_mask2_wr: assert property (bus_req.wr && bus_req.addr == PCU_OFS_MASK2
                                   |=> s_q.mask[2] == ($past(bus_req.wdata) & valid[2]))
        else $error("group 2 mask write lost");

    // masks hold without a write to them
    chk_mask_hold: assert property (!wr_mask |=> $stable(s_q.mask))
        else $error("mask changed without write");

    // group 1 mask never holds its top bit
    chk_mask1_clean: assert property ((s_q.mask[1] & ~valid[1]) == '0)
        else $error("unimplemented mask bit stored");

endmodule : pcu_pin_change

// ---- pcu_pin_drv.sv ----
// far-side pin driver: toggles a pin for each flip bit seen at an edge
module pcu_pin_drv (
    // clock
    input wire logic ref_clk,
    // one bit per pin, high for one cycle to toggle it
    input wire pcu_pkg::pcu_pins_t flip,
    // driven pins, plain levels that hold between toggles
    output pcu_pkg::pcu_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    import pcu_pkg::*;
    pcu_pins_t pins_q = '0;
    assign pins = pins_q;
    // level pins: the model never releases them, so nothing floats
    always @(posedge ref_clk) begin
        pins_q <= pins_q ^ flip;
    end
endmodule : pcu_pin_drv

// ---- tb_pcu_pin_change.sv ----
module tb_pcu_pin_change;
    timeunit 1ns;
    timeprecision 1ns;
    import pcu_pkg::*;
    typedef struct packed {
        logic [1:0] g;
        logic [2:0] b;
        logic [2:0] ctrl;
        logic [7:0] mask;
        logic gie;
        logic [2:0] flags;
    } pcu_row_t;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic gie = 1'b0;
    logic ack = 1'b0;
    logic irq;
    logic [1:0] vec;
    logic [7:0] rdata;
    pcu_bus_req_t req = '0;
    pcu_pins_t flip = '0;
    pcu_pins_t pins;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    // group, bit, control, mask, global enable, expected flags
    pcu_row_t rows [6] = '{'{2'h0, 3'h0, 3'h1, 8'h01, 1'b1, 3'h1},
        '{2'h1, 3'h6, 3'h2, 8'h40, 1'b1, 3'h2},
        '{2'h2, 3'h7, 3'h4, 8'h80, 1'b1, 3'h4},
        '{2'h2, 3'h3, 3'h4, 8'hf7, 1'b1, 3'h0},
        '{2'h0, 3'h5, 3'h6, 8'hff, 1'b1, 3'h0},
        '{2'h1, 3'h0, 3'h2, 8'h01, 1'b0, 3'h2}};
    pcu_pin_drv far (.ref_clk(ref_clk), .flip(flip), .pins(pins));
    pcu_pin_change dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(req), .bus_rdata(rdata), .pins(pins),
        .global_int_en(gie), .irq_ack(ack), .irq(irq), .irq_vector(vec));
    always #20 ref_clk = ~ref_clk;
    // hang guard, far above the roughly 160 cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [7:0] a, input logic [7:0] e);
        checked++;
        if (a !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
        end
    endtask : cmp
    task automatic wr(input logic [PCU_AW-1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [PCU_AW-1:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 cmp(rdata, e);
    endtask : rd
    // one toggle, then wait past the two-edge event latency
    task automatic toggle(input logic [1:0] g, input logic [2:0] b);
        @(posedge ref_clk);
        flip[g][b] <= 1'b1;
        @(posedge ref_clk);
        flip <= '0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : toggle
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(PCU_OFS_CTRL, {5'h00, rows[i].ctrl});
            wr(PCU_OFS_MASK0 + {1'b0, rows[i].g}, rows[i].mask);
            gie <= rows[i].gie;
            toggle(rows[i].g, rows[i].b);
            cmp({7'h00, irq}, {7'h00, rows[i].gie & |(rows[i].flags & rows[i].ctrl)});
            if (irq === 1'b1) cmp({6'h00, vec}, {6'h00, rows[i].g});
            rd(PCU_OFS_FLAGS, {5'h00, rows[i].flags});
            wr(PCU_OFS_FLAGS, 8'hff);
            rd(PCU_OFS_FLAGS, 8'h00);
        end
        // falling edge on a pin, then cleared by interrupt entry
        wr(PCU_OFS_MASK0, 8'h01);
        wr(PCU_OFS_CTRL, 8'h01);
        gie <= 1'b1;
        toggle(2'h0, 3'h0);
        cmp({7'h00, irq}, 8'h01);
        @(posedge ref_clk);
        ack <= 1'b1;
        @(posedge ref_clk);
        ack <= 1'b0;
        #1 cmp({7'h00, irq}, 8'h00);
        rd(PCU_OFS_FLAGS, 8'h00);
        wr(PCU_OFS_MASK1, 8'hff);
        rd(PCU_OFS_MASK1, 8'h7f);
        // second reset in mid-run; all registers and two unmapped places read zero
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 7; a++) rd(3'(a), 8'h00);
        // pin event and write-one clear land on the same edge: the event must win
        wr(PCU_OFS_MASK0, 8'h01);
        wr(PCU_OFS_CTRL, 8'h05);
        gie <= 1'b1;
        @(posedge ref_clk);
        flip[0][0] <= 1'b1;
        @(posedge ref_clk);
        flip <= '0;
        @(posedge ref_clk);
        req <= '{PCU_OFS_FLAGS, 8'hff, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        rd(PCU_OFS_FLAGS, 8'h01);
        wr(PCU_OFS_FLAGS, 8'h01);
        // group 2 request on its own vector, then cleared by entry
        wr(PCU_OFS_MASK2, 8'h01);
        toggle(2'h2, 3'h0);
        cmp({7'h00, irq}, 8'h01);
        cmp({6'h00, vec}, {6'h00, PCU_GRP2});
        @(posedge ref_clk);
        ack <= 1'b1;
        @(posedge ref_clk);
        ack <= 1'b0;
        #1 cmp({7'h00, irq}, 8'h00);
        tally_and_finish();
    end
endmodule : tb_pcu_pin_change
